// ===== smbcs_regs.svh
// How it works
// - bit 7 reads 1 while the interface is bus master and 0 while it is a slave.
// - bit 6 shows whether the byte now in progress is being transmitted or received.
// - start_flag in bit 5 reads 1 once a START or repeated START has been seen on the bus.
// - writing 1 to start_flag asks the master to make a START or repeated START.
// - stop_flag in bit 4 reads 1 for a STOP seen as slave or a STOP still pending as master.
// - writing 1 to stop_flag as master sends STOP after the next ACK, then hardware clears it.
// - ack_request_flag is set for each received byte when software must give the ACK value.
// - arbitration_lost_flag in bit 2 reads 1 after arbitration is lost.
// - arbitration_lost_flag clears whenever the interrupt flag is cleared.
// - as receiver bit 1 is the ACK to send; as transmitter it returns the ACK last received.
// - hardware sets the interrupt flag in bit 0 on each transfer event and never clears it.
// - while the interrupt flag is set, SCL is held low and the bus is stalled.
// - writing 0 to the interrupt flag clears it and advances the sequencer; 1 forces it.
// - the register sits at special-function address 0xC0 and is bit addressable.
`ifndef SMBCS_REGS_SVH
`define SMBCS_REGS_SVH

`define SMBCS_ADDR 8'hC0
`define SMBCS_RESET 8'h00
`define SMBCS_BIT_MASTER 3'd7
`define SMBCS_BIT_TX 3'd6
`define SMBCS_BIT_START 3'd5
`define SMBCS_BIT_STOP 3'd4
`define SMBCS_BIT_ACK_REQUEST_FLAG 3'd3
`define SMBCS_BIT_ARB 3'd2
`define SMBCS_BIT_ACK 3'd1
`define SMBCS_BIT_INT 3'd0

`endif

// ===== smbcs_pkg.sv
`default_nettype none
package smbcs_pkg;
    typedef logic [7:0] smbcs_byte_t;
    typedef logic [2:0] smbcs_bit_t;
endpackage : smbcs_pkg
`default_nettype wire

// ===== smbcs_sfr_write.sv
`timescale 1ns/1ns
`default_nettype none
`include "smbcs_regs.svh"
module smbcs_sfr_write (
    input wire logic [7:0] i_sfr_addr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic i_sfr_we,
    input wire logic [7:0] i_bit_addr,
    input wire logic i_bit_we,
    input wire logic i_bit_val,
    output logic [7:0] o_wmask,
    output logic [7:0] o_wdata
);
    // ----------------------------------------
    // byte and bit write decode
    // ----------------------------------------
    wire logic byte_hit;
    wire logic bit_hit;
    wire logic [7:0] bit_onehot;
    wire logic [7:0] sfr_base;

    assign sfr_base = `SMBCS_ADDR;
    assign byte_hit = i_sfr_we && (i_sfr_addr == sfr_base);
    // bit addresses 0xC0..0xC7 land on bits 0..7
    assign bit_hit = i_bit_we && (i_bit_addr[7:3] == sfr_base[7:3]);
    assign bit_onehot = 8'h01 << i_bit_addr[2:0];
    assign o_wmask = byte_hit ? 8'hFF : (bit_hit ? bit_onehot : 8'h00);
    assign o_wdata = byte_hit ? i_sfr_wdata : (i_bit_val ? 8'hFF : 8'h00);
endmodule : smbcs_sfr_write
`default_nettype wire

// ===== smbcs_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "smbcs_regs.svh"
module smbcs_ctrl (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic [7:0] i_sfr_addr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic i_sfr_we,
    input wire logic i_sfr_re,
    input wire logic [7:0] i_bit_addr,
    input wire logic i_bit_we,
    input wire logic i_bit_val,
    input wire logic i_hardware_ack_enable,
    input wire logic i_ev_start_detected,
    input wire logic i_ev_start_generated,
    input wire logic i_ev_stop_detected,
    input wire logic i_ev_stop_generated,
    input wire logic i_ev_byte_begin,
    input wire logic i_byte_is_tx,
    input wire logic i_ev_byte_received,
    input wire logic i_ev_byte_sent,
    input wire logic i_ev_ack_received,
    input wire logic i_ack_rx_value,
    input wire logic i_ev_arb_lost,
    output logic [7:0] o_sfr_rdata,
    output logic o_master,
    output logic o_transmit_indicator,
    output logic o_start_request,
    output logic o_stop_request,
    output logic o_ack_value,
    output logic o_scl_hold,
    output logic o_advance
);
    // ----------------------------------------
    // write decode
    // ----------------------------------------
    wire logic [7:0] wmask;
    wire logic [7:0] wdata;

    smbcs_sfr_write u_write (
        .i_sfr_addr(i_sfr_addr),
        .i_sfr_wdata(i_sfr_wdata),
        .i_sfr_we(i_sfr_we),
        .i_bit_addr(i_bit_addr),
        .i_bit_we(i_bit_we),
        .i_bit_val(i_bit_val),
        .o_wmask(wmask),
        .o_wdata(wdata)
    );

    // ----------------------------------------
    // state bits
    // ----------------------------------------
    logic master_reg;
    logic tx_reg;
    logic start_reg;
    logic stop_reg;
    logic ack_request_flag_reg;
    logic arb_reg;
    logic ack_reg;
    logic int_reg;
    logic adv_reg;
    smbcs_pkg::smbcs_byte_t rdata_reg;

    wire logic master_next;
    wire logic tx_next;
    wire logic start_next;
    wire logic stop_next;
    wire logic ack_request_flag_next;
    wire logic arb_next;
    wire logic ack_next;
    wire logic int_next;
    wire logic int_clear;
    wire logic hw_event;
    wire logic stop_sw_set;
    wire logic stop_sw_clear;
    wire logic read_hit;
    wire smbcs_pkg::smbcs_byte_t image;

    // read-only bits take no term from their own wmask bit
    assign master_next = i_ev_start_generated
        | (master_reg & ~(i_ev_stop_generated | i_ev_arb_lost));
    assign tx_next = i_ev_byte_begin ? i_byte_is_tx : tx_reg;
    // set wins over a software clear in the same cycle
    assign start_next = i_ev_start_detected | i_ev_start_generated
        | (wmask[`SMBCS_BIT_START] ? wdata[`SMBCS_BIT_START] : start_reg);
    // a slave cannot request a stop
    assign stop_sw_set = wmask[`SMBCS_BIT_STOP] & wdata[`SMBCS_BIT_STOP] & master_reg;
    assign stop_sw_clear = wmask[`SMBCS_BIT_STOP] & ~wdata[`SMBCS_BIT_STOP];
    assign stop_next = (i_ev_stop_detected & ~master_reg) | stop_sw_set
        | (stop_reg & ~stop_sw_clear & ~i_ev_stop_generated);
    assign int_clear = wmask[`SMBCS_BIT_INT] & ~wdata[`SMBCS_BIT_INT];
    assign ack_request_flag_next = (i_ev_byte_received & ~i_hardware_ack_enable)
        | (ack_request_flag_reg & ~int_clear);
    assign arb_next = i_ev_arb_lost | (arb_reg & ~int_clear);
    // received ack overrides a write landing in the same cycle
    assign ack_next = i_ev_ack_received ? i_ack_rx_value
        : (wmask[`SMBCS_BIT_ACK] ? wdata[`SMBCS_BIT_ACK] : ack_reg);
    assign hw_event = i_ev_start_detected | i_ev_start_generated | i_ev_stop_detected
        | i_ev_stop_generated | i_ev_byte_received | i_ev_byte_sent | i_ev_arb_lost;
    assign int_next = hw_event
        | (wmask[`SMBCS_BIT_INT] ? wdata[`SMBCS_BIT_INT] : int_reg);
    assign image = {master_reg, tx_reg, start_reg, stop_reg, ack_request_flag_reg, arb_reg, ack_reg,
        int_reg};
    assign read_hit = i_sfr_re && (i_sfr_addr == `SMBCS_ADDR);

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            {master_reg, tx_reg, start_reg, stop_reg, ack_request_flag_reg, arb_reg, ack_reg, int_reg}
                <= `SMBCS_RESET;
            adv_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            master_reg <= master_next;
            tx_reg <= tx_next;
            start_reg <= start_next;
            stop_reg <= stop_next;
            ack_request_flag_reg <= ack_request_flag_next;
            arb_reg <= arb_next;
            ack_reg <= ack_next;
            int_reg <= int_next;
            adv_reg <= int_clear & int_reg & ~hw_event;
            rdata_reg <= read_hit ? image : 8'h00;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign o_sfr_rdata = rdata_reg;
    assign o_master = master_reg;
    assign o_transmit_indicator = tx_reg;
    assign o_start_request = start_reg;
    assign o_stop_request = stop_reg & master_reg;
    // sda follows the written value at once; scl stays held until the flag drops
    assign o_ack_value = ack_reg;
    assign o_scl_hold = int_reg;
    assign o_advance = adv_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_resetn);

    a_master_on_start: assert property (
        i_ev_start_generated |=> o_master)
        else $error("master not set after start");
    a_master_arb_drop: assert property (
        o_master && i_ev_arb_lost && !i_ev_start_generated |=> !o_master)
        else $error("master kept after lost arbitration");
    a_tx_load_byte: assert property (
        i_ev_byte_begin |=> o_transmit_indicator == $past(i_byte_is_tx))
        else $error("transmit indicator wrong");
    a_start_on_event: assert property (
        i_ev_start_detected || i_ev_start_generated |=> start_reg)
        else $error("start flag not set by start event");
    a_start_write: assert property (
        wmask[`SMBCS_BIT_START] && !wdata[`SMBCS_BIT_START]
        && !i_ev_start_detected && !i_ev_start_generated |=> !o_start_request)
        else $error("start request kept after writing zero");
    a_stop_slave_seen: assert property (
        i_ev_stop_detected && !master_reg |=> stop_reg)
        else $error("stop flag not set by slave stop");
    a_stop_hw_clear: assert property (
        i_ev_stop_generated && !i_ev_stop_detected && !stop_sw_set |=> !stop_reg)
        else $error("stop flag not cleared after stop sent");
    a_stop_slave_ignore: assert property (
        !master_reg && !stop_reg && !i_ev_stop_detected |=> !stop_reg)
        else $error("slave stop flag set by write");
    a_ack_request_flag_on_rx: assert property (
        i_ev_byte_received && !i_hardware_ack_enable |=> ack_request_flag_reg [*1] ##0 o_scl_hold)
        else $error("ack request or interrupt missing after byte");
    a_arb_on_lost: assert property (
        i_ev_arb_lost |=> arb_reg)
        else $error("arbitration flag not set");
    a_arb_si_clear: assert property (
        arb_reg && int_clear && !i_ev_arb_lost |=> !arb_reg)
        else $error("arbitration flag survives interrupt clear");
    a_ack_rx_load: assert property (
        i_ev_ack_received |=> o_ack_value == $past(i_ack_rx_value))
        else $error("received ack not stored");
    a_ack_write: assert property (
        wmask[`SMBCS_BIT_ACK] && !i_ev_ack_received |=> o_ack_value == $past(wdata[`SMBCS_BIT_ACK]))
        else $error("written ack value not taken");
    a_int_sticky: assert property (
        int_reg && !int_clear |=> int_reg)
        else $error("interrupt flag cleared by hardware");
    a_scl_stall: assert property (
        hw_event |=> o_scl_hold)
        else $error("scl not held");
    a_int_force: assert property (
        wmask[`SMBCS_BIT_INT] && wdata[`SMBCS_BIT_INT] |=> o_scl_hold)
        else $error("forced interrupt not set");
    a_int_clear: assert property (
        int_clear && !hw_event |=> !o_scl_hold)
        else $error("interrupt flag not cleared by write");
    a_advance_pulse: assert property (
        int_reg && int_clear && !hw_event |=> o_advance && !o_scl_hold ##1 !o_advance)
        else $error("advance pulse wrong");

    // ----------------------------------------
    // checks: register port
    // ----------------------------------------
    a_read_image: assert property (
        read_hit |=> o_sfr_rdata[0] == $past(int_reg) && o_sfr_rdata[7] == $past(master_reg))
        else $error("read data mismatch");
    a_read_miss: assert property (
        !read_hit |=> o_sfr_rdata == 8'h00)
        else $error("read data without a read hit");
    a_ro_write: assert property (
        wmask[`SMBCS_BIT_ACK_REQUEST_FLAG] && !ack_request_flag_reg && !i_ev_byte_received |=> !ack_request_flag_reg)
        else $error("read-only bit changed by write");
    // master may only move on bus events, never on a write
    a_ro_master_write: assert property (
        wmask[`SMBCS_BIT_MASTER] && !i_ev_start_generated
        && !i_ev_stop_generated && !i_ev_arb_lost |=> $stable(o_master))
        else $error("master bit changed by write");
    a_ro_tx_write: assert property (
        wmask[`SMBCS_BIT_TX] && !i_ev_byte_begin |=> $stable(o_transmit_indicator))
        else $error("transmit bit changed by write");
endmodule : smbcs_ctrl
`default_nettype wire

// ===== smbcs_bus_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------
// far-side bus events
// ----------
module smbcs_bus_model (
    input wire logic i_clock,
    output logic [8:0] o_ev,
    output logic o_level
);
    initial begin
        o_ev = 9'h000;
        o_level = 1'b0;
    end
    // one-cycle event; level inverted once its hold is over
    task automatic pulse(input int k, input logic v);
        @(negedge i_clock);
        o_ev = 9'h001 << k;
        o_level = v;
        @(negedge i_clock);
        o_ev = 9'h000;
        o_level = ~v;
    endtask : pulse
endmodule : smbcs_bus_model
`default_nettype wire

// ===== test_smbus_control_status.sv
`timescale 1ns/1ns
`default_nettype none
module test_smbus_control_status;
    logic i_clock, i_resetn, we, re, bwe, bval, hack, lvl;
    logic [7:0] addr, wdata, baddr, rdata;
    logic [8:0] ev;
    logic mst, txi, sreq, preq, ackv, hold, adv;
    int error_cnt = 0;
    int tests_run = 0;
    smbcs_bus_model bm (.i_clock(i_clock), .o_ev(ev), .o_level(lvl));
    smbcs_ctrl uut (.i_clock(i_clock), .i_resetn(i_resetn), .i_sfr_addr(addr),
        .i_sfr_wdata(wdata), .i_sfr_we(we), .i_sfr_re(re), .i_bit_addr(baddr),
        .i_bit_we(bwe), .i_bit_val(bval), .i_hardware_ack_enable(hack),
        .i_ev_start_detected(ev[0]), .i_ev_start_generated(ev[1]),
        .i_ev_stop_detected(ev[2]), .i_ev_stop_generated(ev[3]),
        .i_ev_byte_begin(ev[4]), .i_byte_is_tx(lvl), .i_ev_byte_received(ev[5]),
        .i_ev_byte_sent(ev[6]), .i_ev_ack_received(ev[7]), .i_ack_rx_value(lvl),
        .i_ev_arb_lost(ev[8]), .o_sfr_rdata(rdata), .o_master(mst),
        .o_transmit_indicator(txi), .o_start_request(sreq), .o_stop_request(preq),
        .o_ack_value(ackv), .o_scl_hold(hold), .o_advance(adv));
    initial begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clock);
        addr = a;
        wdata = d;
        we = 1'b1;
        @(negedge i_clock);
        we = 1'b0;
    endtask : wr
    task automatic bw(input logic [2:0] b, input logic v);
        @(negedge i_clock);
        baddr = 8'hc0 + {5'h00, b};
        bval = v;
        bwe = 1'b1;
        @(negedge i_clock);
        bwe = 1'b0;
    endtask : bw
    // read data stands one cycle only, so it is sampled right after the read edge
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(negedge i_clock);
        addr = a;
        re = 1'b1;
        @(negedge i_clock);
        re = 1'b0;
        cmp(rdata & m, e);
    endtask : rd
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up
    task automatic t_basic();
        rd(8'hc0, 8'hff, 8'h00);
        cmp({mst, txi, sreq, preq, ackv, hold, adv, 1'b0}, 8'h00);
        wr(8'hc0, 8'hff);
        rd(8'hc0, 8'hff, 8'h23);
        cmp({7'h00, sreq}, 8'h01);
        bw(3'h7, 1'b1);
        bw(3'h6, 1'b1);
        bw(3'h3, 1'b1);
        bw(3'h2, 1'b1);
        rd(8'hc0, 8'hcc, 8'h00);
        rd(8'hc1, 8'hff, 8'h00);
        wr(8'hc0, 8'h00);
        cmp({7'h00, adv}, 8'h01);
        $display("basic test done");
    endtask : t_basic
    task automatic t_master();
        bm.pulse(1, 1'b0);
        cmp({6'h00, mst, hold}, 8'h03);
        wr(8'hc0, 8'h00);
        bw(3'h4, 1'b1);
        cmp({7'h00, preq}, 8'h01);
        rd(8'hc0, 8'h90, 8'h90);
        bm.pulse(3, 1'b0);
        rd(8'hc0, 8'h91, 8'h01);
        wr(8'hc0, 8'h00);
        // lose arbitration while master
        bm.pulse(1, 1'b0);
        bm.pulse(8, 1'b0);
        rd(8'hc0, 8'h85, 8'h05);
        bw(3'h0, 1'b0);
        cmp({7'h00, adv}, 8'h01);
        rd(8'hc0, 8'h05, 8'h00);
        $display("master test done");
    endtask : t_master
    task automatic t_bytes();
        bm.pulse(4, 1'b0);
        cmp({7'h00, txi}, 8'h00);
        bm.pulse(5, 1'b0);
        rd(8'hc0, 8'h09, 8'h09);
        bw(3'h1, 1'b1);
        cmp({7'h00, ackv}, 8'h01);
        wr(8'hc0, 8'h00);
        rd(8'hc0, 8'h0b, 8'h00);
        bm.pulse(4, 1'b1);
        cmp({7'h00, txi}, 8'h01);
        bm.pulse(7, 1'b1);
        rd(8'hc0, 8'h02, 8'h02);
        bm.pulse(6, 1'b0);
        repeat (6) @(negedge i_clock);
        cmp({7'h00, hold}, 8'h01);
        wr(8'hc0, 8'h00);
        bm.pulse(0, 1'b0);
        rd(8'hc0, 8'h21, 8'h21);
        bm.pulse(2, 1'b0);
        rd(8'hc0, 8'h10, 8'h10);
        $display("byte test done");
    endtask : t_bytes
    // slave stop write is refused; hardware ack mode raises no ack request
    task automatic t_hw_ack();
        wr(8'hc0, 8'h00);
        cmp({7'h00, sreq}, 8'h00);
        bw(3'h4, 1'b1);
        rd(8'hc0, 8'h10, 8'h00);
        @(negedge i_clock);
        hack = 1'b1;
        bm.pulse(5, 1'b0);
        rd(8'hc0, 8'h09, 8'h01);
        hack = 1'b0;
        $display("hardware ack test done");
    endtask : t_hw_ack
    // mid-run reset with flags set must leave every output low
    task automatic t_reset();
        @(negedge i_clock);
        i_resetn = 1'b0;
        repeat (2) @(negedge i_clock);
        i_resetn = 1'b1;
        cmp({mst, txi, sreq, preq, ackv, hold, adv, 1'b0}, 8'h00);
        rd(8'hc0, 8'hff, 8'h00);
        $display("reset test done");
    endtask : t_reset
    initial begin
        {i_resetn, we, re, bwe, bval, hack} = 6'h00;
        {addr, wdata, baddr} = 24'h00_0000;
        repeat (16) @(posedge i_clock);
        @(negedge i_clock);
        i_resetn = 1'b1;
        t_basic();
        t_master();
        t_bytes();
        t_hw_ack();
        t_reset();
        wrap_up();
    end
endmodule : test_smbus_control_status
`default_nettype wire
